// [can_config_command_handler.sv]
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_regs.svh"

module can_config_command_handler
  import can_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] rotary_sw,
  input wire logic [63:0] hb_status,
  output logic [3:0] bitrate_code,
  output logic program_halt
);

  // ****************************************
  // Declarations
  // ****************************************
  cmd_state_type state_reg;
  cmd_state_type state_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  word_type hrdata_reg;
  word_type hrdata_next;
  logic hready_reg;
  logic hready_next;
  logic [7:0] cmd_code_reg;
  logic [7:0] cmd_code_next;
  word_type arg_reg [4];
  word_type arg_next [4];
  word_type user_reg [`USER_REGS];
  word_type user_next [`USER_REGS];
  logic [3:0] bitrate_reg;
  logic [3:0] bitrate_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic halt_reg;
  logic halt_next;
  logic [3:0] rot_meta_reg;
  logic [3:0] rot_sync_reg;
  logic addr_phase;
  logic ack_set;
  logic err_set;
  logic halt_set;
  logic [3:0] rn;
  logic [3:0] rn_hi;
  logic reg_ok;
  logic client_ok;
  word_type node_id;
  word_type read_mux;

  dict_bus_if dict ();

  object_dictionary u_dict
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .rotary_pos(rot_sync_reg),
    .hb_status(hb_status),
    .bus(dict.dict)
  );

  // Direct codes and switch positions share one table; a switch position above 8 falls to 1 Mbit/s
  function automatic logic [3:0] rate_of(input logic [15:0] code);
    rate_of = (code <= `RATE_MAX_CODE) ? code[3:0] : `RATE_1M;
  endfunction

  // ****************************************
  // Rotary switch synchroniser
  // ****************************************
  // The switch is a free pin, so two stages before anything looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rot_meta_reg <= 4'h0;
      rot_sync_reg <= 4'h0;
    end
    else
    begin
      rot_meta_reg <= rotary_sw;
      rot_sync_reg <= rot_meta_reg;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Reads take one wait state so a write just before is always seen
  always_comb
  begin
    addr_phase = hsel && htrans[1] && hready;
    wr_pend_next = addr_phase && hwrite;
    rd_pend_next = addr_phase && !hwrite;
    addr_next = addr_phase ? haddr[7:0] : addr_reg;
    hready_next = !(addr_phase && !hwrite);
    read_mux = 32'h0000_0000;
    if (addr_reg == `OFS_CMD)
      read_mux = {24'h00_0000, cmd_code_reg};
    else if (addr_reg == `OFS_ARG0)
      read_mux = arg_reg[0];
    else if (addr_reg == `OFS_ARG1)
      read_mux = arg_reg[1];
    else if (addr_reg == `OFS_ARG2)
      read_mux = arg_reg[2];
    else if (addr_reg == `OFS_ARG3)
      read_mux = arg_reg[3];
    else if (addr_reg == `OFS_STATUS)
      read_mux = {20'h0_0000, rot_sync_reg, bitrate_reg, halt_reg, err_reg, ack_reg, state_reg != ST_IDLE};
    else if (addr_reg >= `OFS_USER_FIRST && addr_reg <= `OFS_USER_LAST && addr_reg[1:0] == 2'b00)
      read_mux = user_reg[addr_reg[5:2]];
    hrdata_next = rd_pend_reg ? read_mux : hrdata_reg;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign bitrate_code = bitrate_reg;
  assign program_halt = halt_reg;

  // ****************************************
  // Command sequencer
  // ****************************************
  // One cycle per command, plus three dictionary writes for link setup
  always_comb
  begin
    state_next = state_reg;
    cmd_code_next = cmd_code_reg;
    arg_next = arg_reg;
    user_next = user_reg;
    bitrate_next = bitrate_reg;
    ack_set = 1'b0;
    err_set = 1'b0;
    halt_set = 1'b0;
    rn = arg_reg[1][3:0];
    rn_hi = rn + 4'h1;
    reg_ok = (arg_reg[1] <= `USER_LAST_NUM) && !(dict.two_word && rn == 4'hF);
    client_ok = (arg_reg[1] == 32'h0000_0001) || (arg_reg[1] == 32'h0000_0002);
    node_id = {25'h000_0000, arg_reg[0][6:0]};
    dict.wr = 1'b0;
    dict.index = arg_reg[2][15:0];
    dict.sub = arg_reg[3][7:0];
    dict.wdata = {32'h0000_0000, arg_reg[1]};
    // Bus writes to the command file; a command in flight freezes it
    if (wr_pend_reg && state_reg == ST_IDLE)
    begin
      if (addr_reg == `OFS_CMD)
      begin
        cmd_code_next = hwdata[7:0];
        state_next = ST_EXEC;
      end
      else if (addr_reg == `OFS_ARG0)
        arg_next[0] = hwdata;
      else if (addr_reg == `OFS_ARG1)
        arg_next[1] = hwdata;
      else if (addr_reg == `OFS_ARG2)
        arg_next[2] = hwdata;
      else if (addr_reg == `OFS_ARG3)
        arg_next[3] = hwdata;
    end
    if (wr_pend_reg && addr_reg >= `OFS_USER_FIRST && addr_reg <= `OFS_USER_LAST && addr_reg[1:0] == 2'b00)
      user_next[addr_reg[5:2]] = hwdata;
    case (state_reg)
      ST_IDLE:
      begin
      end
      ST_EXEC:
      begin
        state_next = ST_IDLE;
        if (cmd_code_reg == `CODE_BITRATE)
        begin
          if (arg_reg[0][31:16] == 16'h0000 && arg_reg[0][15:0] <= `RATE_MAX_CODE)
          begin
            bitrate_next = rate_of(arg_reg[0][15:0]);
            ack_set = 1'b1;
          end
          else if (arg_reg[0] == {16'h0000, `ROTARY_SEL})
          begin
            bitrate_next = rate_of({12'h000, rot_sync_reg});
            ack_set = 1'b1;
          end
          else
            err_set = 1'b1;
        end
        else if (cmd_code_reg == `CODE_LOCAL)
        begin
          // Each mode checks the object and, where used, the register number
          if (!dict.hit)
            err_set = 1'b1;
          else if (arg_reg[0] == {16'h0000, `MODE_READ})
          begin
            if (reg_ok)
            begin
              user_next[rn] = dict.rdata[31:0];
              if (dict.two_word)
                user_next[rn_hi] = dict.rdata[63:32];
              ack_set = 1'b1;
            end
            else
              err_set = 1'b1;
          end
          else if (arg_reg[0] == {16'h0000, `MODE_WRITE_REG} && dict.writable && reg_ok)
          begin
            dict.wr = 1'b1;
            dict.wdata = {dict.two_word ? user_reg[rn_hi] : 32'h0000_0000, user_reg[rn]};
            ack_set = 1'b1;
          end
          else if (arg_reg[0] == {16'h0000, `MODE_WRITE_CONST} && dict.writable && !dict.two_word)
          begin
            dict.wr = 1'b1;
            ack_set = 1'b1;
          end
          else
            err_set = 1'b1;
          halt_set = err_set;
        end
        else if (cmd_code_reg == `CODE_LINK && client_ok)
          state_next = ST_LINK1;
        else
          err_set = 1'b1;
      end
      ST_LINK1, ST_LINK2, ST_LINK3:
      begin
        // Client number 2 picks the second client object
        dict.wr = 1'b1;
        dict.index = arg_reg[1][1] ? `IDX_CLIENT2 : `IDX_CLIENT1;
        if (state_reg == ST_LINK1)
        begin
          dict.sub = 8'h01;
          dict.wdata = {32'h0000_0000, `SDO_TX_BASE + node_id};
          state_next = ST_LINK2;
        end
        else if (state_reg == ST_LINK2)
        begin
          dict.sub = 8'h02;
          dict.wdata = {32'h0000_0000, `SDO_RX_BASE + node_id};
          state_next = ST_LINK3;
        end
        else
        begin
          dict.sub = 8'h03;
          dict.wdata = {32'h0000_0000, node_id};
          state_next = ST_IDLE;
          ack_set = 1'b1;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    // Sticky flags; a set in the same cycle as a clear wins
    ack_next = ack_set || (ack_reg && !(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_ACK_BIT]));
    err_next = err_set || (err_reg && !(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_ERR_BIT]));
    halt_next = halt_set || (halt_reg && !(wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[`ST_HALT_BIT]));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      cmd_code_reg <= 8'h00;
      arg_reg <= '{`ARG_RST, `ARG_RST, `ARG_RST, `ARG_RST};
      user_reg <= '{default: `USER_RST};
      bitrate_reg <= `RATE_1M;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_code_reg <= cmd_code_next;
      arg_reg <= arg_next;
      user_reg <= user_next;
      bitrate_reg <= bitrate_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      halt_reg <= halt_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_link_walk;
    (state_reg == ST_LINK1 && dict.wr && dict.sub == 8'h01) ##1
    (state_reg == ST_LINK2 && dict.wr && dict.sub == 8'h02) ##1
    (state_reg == ST_LINK3 && dict.wr && dict.sub == 8'h03);
  endsequence

  sequence s_exec_rate;
    state_reg == ST_EXEC && cmd_code_reg == `CODE_BITRATE;
  endsequence

  a_reset_rate: assert property (
    @(posedge hclk) $rose(hresetn) |-> bitrate_reg == `RATE_1M)
    else $error("bit rate not 1 Mbit/s after reset");

  a_direct_rate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_exec_rate and arg_reg[0] <= 32'h0000_0008) |=> bitrate_reg == $past(arg_reg[0][3:0]))
    else $error("direct rate code not applied");

  a_code_five: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_exec_rate and arg_reg[0] == 32'h0000_0005) |=> bitrate_reg == `RATE_100K)
    else $error("code 5 did not give 100 kbit/s");

  a_rotary_rate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_exec_rate and arg_reg[0] == 32'h0000_00FF) |=>
      bitrate_reg == (($past(rot_sync_reg) > 4'h8) ? `RATE_1M : $past(rot_sync_reg)))
    else $error("rotary rate not applied");

  a_link_writes: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_EXEC && cmd_code_reg == `CODE_LINK && client_ok) |=> s_link_walk ##1 ack_reg)
    else $error("link setup did not make three writes then acknowledge");

  a_invalid_halt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_EXEC && cmd_code_reg == `CODE_LOCAL && !dict.hit) |=> (err_reg && program_halt))
    else $error("invalid access did not error and halt");

  a_local_ack: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_EXEC && cmd_code_reg == `CODE_LOCAL && dict.hit && dict.writable && !dict.two_word
      && arg_reg[0] == 32'h0000_0002) |=> (ack_reg && state_reg == ST_IDLE))
    else $error("constant write not acknowledged");

  a_bad_rate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_exec_rate and arg_reg[0] > 32'h0000_0008 && arg_reg[0] != 32'h0000_00FF) |=>
      (err_reg && $stable(bitrate_reg)))
    else $error("bad rate code not rejected");

endmodule

`default_nettype wire

// [can_cmd_regs.svh]
`ifndef CAN_CMD_REGS_SVH
`define CAN_CMD_REGS_SVH

// ****************************************
// Register offsets (byte addresses, low byte)
// ****************************************
`define OFS_CMD 8'h00
`define OFS_ARG0 8'h04
`define OFS_ARG1 8'h08
`define OFS_ARG2 8'h0C
`define OFS_ARG3 8'h10
`define OFS_STATUS 8'h14
`define OFS_USER_FIRST 8'h40
`define OFS_USER_LAST 8'h7C

// ****************************************
// Status register fields and reset values
// ****************************************
`define ST_BUSY_BIT 0
`define ST_ACK_BIT 1
`define ST_ERR_BIT 2
`define ST_HALT_BIT 3
`define ST_RATE_LSB 4
`define ST_ROT_LSB 8
`define ARG_RST 32'h0000_0000
`define USER_RST 32'h0000_0000
`define USER_REGS 16
`define USER_LAST_NUM 32'h0000_000F

// ****************************************
// Command codes and arguments
// ****************************************
`define CODE_BITRATE 8'h47
`define CODE_LOCAL 8'h48
`define CODE_LINK 8'hA0
`define RATE_MAX_CODE 16'h0008
`define ROTARY_SEL 16'h00FF
`define RATE_1M 4'h0
`define RATE_100K 4'h5
`define MODE_READ 16'h0000
`define MODE_WRITE_REG 16'h0001
`define MODE_WRITE_CONST 16'h0002

// ****************************************
// Dictionary objects
// ****************************************
`define IDX_SYNC_PERIOD 16'h1006
`define IDX_TIME_OF_DAY 16'h1012
`define IDX_CLIENT1 16'h1280
`define IDX_CLIENT2 16'h1281
`define IDX_HB_STATUS 16'h2005
`define IDX_ROTARY 16'h200A
`define SDO_TX_BASE 32'h0000_0600
`define SDO_RX_BASE 32'h0000_0580
`define SYNC_PERIOD_RST 32'h0000_0000
`define TOD_RST 64'h0000_0000_0000_0000
`define CLIENT_RST 32'h0000_0000
`define HB_CONSUMERS 32'h0000_0008
`define CLIENT_SUBS 32'h0000_0003

`endif

// [can_cmd_pkg.sv]
package can_cmd_pkg;

  // Command sequencer states, Gray coded along the link setup walk
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_LINK1 = 3'b011,
    ST_LINK2 = 3'b010,
    ST_LINK3 = 3'b110
  } cmd_state_type;

  typedef logic [31:0] word_type;

endpackage

// [dict_bus_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Access port of the local object dictionary
interface dict_bus_if;
  logic wr;
  logic [15:0] index;
  logic [7:0] sub;
  logic [63:0] wdata;
  logic [63:0] rdata;
  logic hit;
  logic writable;
  logic two_word;

  modport requester
  (
    output wr,
    output index,
    output sub,
    output wdata,
    input rdata,
    input hit,
    input writable,
    input two_word
  );

  modport dict
  (
    input wr,
    input index,
    input sub,
    input wdata,
    output rdata,
    output hit,
    output writable,
    output two_word
  );
endinterface

`default_nettype wire

// [object_dictionary.sv]
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_regs.svh"

module object_dictionary
  import can_cmd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] rotary_pos,
  input wire logic [63:0] hb_status,
  dict_bus_if.dict bus
);

  word_type sync_period_reg;
  word_type sync_period_next;
  logic [63:0] tod_reg;
  logic [63:0] tod_next;
  word_type cob_tx_reg [2];
  word_type cob_tx_next [2];
  word_type cob_rx_reg [2];
  word_type cob_rx_next [2];
  word_type node_reg [2];
  word_type node_next [2];
  logic [2:0] slot;
  logic clt;

  // ****************************************
  // Object lookup, purely combinational
  // ****************************************
  always_comb
  begin
    bus.rdata = 64'h0000_0000_0000_0000;
    bus.hit = 1'b0;
    bus.writable = 1'b0;
    bus.two_word = 1'b0;
    clt = bus.index[0];
    slot = bus.sub[2:0] - 3'h1;
    if (bus.index == `IDX_SYNC_PERIOD && bus.sub == 8'h00)
    begin
      bus.rdata = {32'h0000_0000, sync_period_reg};
      bus.hit = 1'b1;
      bus.writable = 1'b1;
    end
    else if (bus.index == `IDX_TIME_OF_DAY && bus.sub == 8'h00)
    begin
      bus.rdata = tod_reg;
      bus.hit = 1'b1;
      bus.writable = 1'b1;
      bus.two_word = 1'b1;
    end
    else if (bus.index == `IDX_ROTARY && bus.sub == 8'h00)
    begin
      bus.rdata = {56'h0000_0000_0000_00, rotary_pos, 4'h0};
      bus.hit = 1'b1;
    end
    else if (bus.index == `IDX_HB_STATUS)
    begin
      // Sub-index 0 is the consumer count; 1 to 8 are one status byte each
      if (bus.sub == 8'h00)
      begin
        bus.rdata = {32'h0000_0000, `HB_CONSUMERS};
        bus.hit = 1'b1;
      end
      else if (bus.sub <= `HB_CONSUMERS)
      begin
        bus.rdata = {56'h0000_0000_0000_00, hb_status[{slot, 3'b000} +: 8]};
        bus.hit = 1'b1;
      end
    end
    else if (bus.index == `IDX_CLIENT1 || bus.index == `IDX_CLIENT2)
    begin
      bus.hit = (bus.sub <= `CLIENT_SUBS);
      bus.writable = (bus.sub != 8'h00) && (bus.sub <= `CLIENT_SUBS);
      case (bus.sub)
        8'h00: bus.rdata = {32'h0000_0000, `CLIENT_SUBS};
        8'h01: bus.rdata = {32'h0000_0000, cob_tx_reg[clt]};
        8'h02: bus.rdata = {32'h0000_0000, cob_rx_reg[clt]};
        8'h03: bus.rdata = {32'h0000_0000, node_reg[clt]};
        default: bus.rdata = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  // Writes land only on objects that answered as writable
  always_comb
  begin
    sync_period_next = sync_period_reg;
    tod_next = tod_reg;
    cob_tx_next = cob_tx_reg;
    cob_rx_next = cob_rx_reg;
    node_next = node_reg;
    if (bus.wr && bus.writable)
    begin
      if (bus.index == `IDX_SYNC_PERIOD)
        sync_period_next = bus.wdata[31:0];
      else if (bus.index == `IDX_TIME_OF_DAY)
        tod_next = bus.wdata;
      else if (bus.sub == 8'h01)
        cob_tx_next[clt] = bus.wdata[31:0];
      else if (bus.sub == 8'h02)
        cob_rx_next[clt] = bus.wdata[31:0];
      else
        node_next[clt] = bus.wdata[31:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_period_reg <= `SYNC_PERIOD_RST;
      tod_reg <= `TOD_RST;
      cob_tx_reg <= '{`CLIENT_RST, `CLIENT_RST};
      cob_rx_reg <= '{`CLIENT_RST, `CLIENT_RST};
      node_reg <= '{`CLIENT_RST, `CLIENT_RST};
    end
    else
    begin
      sync_period_reg <= sync_period_next;
      tod_reg <= tod_next;
      cob_tx_reg <= cob_tx_next;
      cob_rx_reg <= cob_rx_next;
      node_reg <= node_next;
    end
  end

  a_rotary_report: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bus.index == `IDX_ROTARY && bus.sub == 8'h00) |-> (bus.hit && bus.rdata[7:4] == rotary_pos))
    else $error("rotary position not reported in object bits 7:4");

  a_sync_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bus.wr && bus.index == `IDX_SYNC_PERIOD && bus.sub == 8'h00) |=> sync_period_reg == $past(bus.wdata[31:0]))
    else $error("sync period write not taken");

endmodule

`default_nettype wire

// [field_side_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Far side: rotary selector and heartbeat consumers
// ****************************************
module field_side_model
(
  input wire logic [3:0] pos,
  output logic [3:0] rotary_sw,
  output logic [63:0] hb_status
);
  // Switch follows the knob; one status byte per consumer, consumer 1 lowest
  assign rotary_sw = pos;
  assign hb_status = 64'h0807_0605_0403_027F;
endmodule

`default_nettype wire

// [can_config_command_handler_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "can_cmd_regs.svh"

module can_config_command_handler_tb
  import can_cmd_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] pos = 4'h0;
  logic [3:0] rotary_sw;
  logic [3:0] bitrate_code;
  logic [31:0] hrdata;
  logic [63:0] hb_status;
  logic hreadyout;
  logic hresp;
  logic program_halt;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  word_type v;
  word_type nd;

  can_config_command_handler can_config_command_handler_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rotary_sw(rotary_sw), .hb_status(hb_status),
    .bitrate_code(bitrate_code), .program_halt(program_halt));

  field_side_model field_side_model_i (.pos(pos), .rotary_sw(rotary_sw), .hb_status(hb_status));

  // ****************************************
  // Clock, timeout and report
  // ****************************************
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end

  // A hung wait on the bus ends the run instead of stalling it
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string name, input word_type seen, input word_type exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ****************************************
  // Bus master tasks
  // ****************************************
  // Ready is read at the falling edge, where it already holds its value for the next rising edge
  task wait_rdy(output word_type d);
    logic r;
    r = 1'b0;
    d = 32'h0000_0000;
    while (r !== 1'b1)
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end
  endtask

  task xfer(input logic [7:0] a, input logic w, input word_type wd, output word_type rd_v);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy(rd_v);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd_v);
  endtask

  task wr(input logic [7:0] a, input word_type d);
    word_type dummy;
    xfer(a, 1'b1, d, dummy);
  endtask

  task rd(input logic [7:0] a, output word_type d);
    xfer(a, 1'b0, 32'h0000_0000, d);
  endtask

  function automatic logic [7:0] ureg(input int n);
    return `OFS_USER_FIRST + 8'(4 * n);
  endfunction

  // Arguments first, then the code; poll busy, check outcome, clear sticky bits
  task run(input logic [7:0] code, input word_type a0, a1, a2, a3, input logic err);
    word_type s;
    logic hx;
    hx = err && (code == `CODE_LOCAL);
    wr(`OFS_ARG0, a0);
    wr(`OFS_ARG1, a1);
    wr(`OFS_ARG2, a2);
    wr(`OFS_ARG3, a3);
    wr(`OFS_CMD, {24'h00_0000, code});
    do rd(`OFS_STATUS, s); while (s[0] !== 1'b0);
    chk("status_flags", {29'h0, s[3:1]}, {29'h0, hx, err, ~err});
    chk("halt_pin", {31'h0, program_halt}, {31'h0, hx});
    chk("bus_resp", {31'h0, hresp}, 32'h0000_0000);
    wr(`OFS_STATUS, 32'h0000_000E);
  endtask

  // Copy an object into user register 14 and read it back
  task getobj(input logic [15:0] idx, input logic [7:0] sub, output word_type d);
    run(`CODE_LOCAL, `MODE_READ, 32'h0000_000E, {16'h0, idx}, {24'h0, sub}, 1'b0);
    rd(ureg(14), d);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("rate_reset", {28'h0, bitrate_code}, 32'h0000_0000);
    chk("ready_reset", {31'h0, hreadyout}, 32'h0000_0001);
    for (int i = 0; i <= 8; i++)
    begin
      run(`CODE_BITRATE, word_type'(i), 0, 0, 0, 1'b0);
      chk("rate_code", {28'h0, bitrate_code}, word_type'(i));
    end
    run(`CODE_BITRATE, 32'h0000_0009, 0, 0, 0, 1'b1);
    chk("rate_kept", {28'h0, bitrate_code}, 32'h0000_0008);
    pos <= 4'hB;
    run(`CODE_BITRATE, {16'h0, `ROTARY_SEL}, 0, 0, 0, 1'b0);
    chk("rate_knob_high", {28'h0, bitrate_code}, {28'h0, `RATE_1M});
    pos <= 4'h6;
    run(`CODE_BITRATE, {16'h0, `ROTARY_SEL}, 0, 0, 0, 1'b0);
    chk("rate_knob", {28'h0, bitrate_code}, 32'h0000_0006);
    getobj(`IDX_ROTARY, 8'h00, v);
    chk("knob_object", {28'h0, v[7:4]}, 32'h0000_0006);
    run(`CODE_LOCAL, `MODE_WRITE_CONST, 32'h0000_03E8, {16'h0, `IDX_SYNC_PERIOD}, 0, 1'b0);
    getobj(`IDX_SYNC_PERIOD, 8'h00, v);
    chk("sync_const", v, 32'h0000_03E8);
    wr(ureg(2), 32'h1234_5678);
    run(`CODE_LOCAL, `MODE_WRITE_REG, 32'h0000_0002, {16'h0, `IDX_SYNC_PERIOD}, 0, 1'b0);
    getobj(`IDX_SYNC_PERIOD, 8'h00, v);
    chk("sync_reg", v, 32'h1234_5678);
    getobj(`IDX_HB_STATUS, 8'h01, v);
    chk("heartbeat_1", v, 32'h0000_007F);
    for (int c = 1; c <= 2; c++)
    begin
      nd = (c == 1) ? 32'h0000_007F : 32'h0000_0005;
      run(`CODE_LINK, nd, word_type'(c), 0, 0, 1'b0);
      getobj((c == 1) ? `IDX_CLIENT1 : `IDX_CLIENT2, 8'h01, v);
      chk("client_tx", v, `SDO_TX_BASE + nd);
      getobj((c == 1) ? `IDX_CLIENT1 : `IDX_CLIENT2, 8'h02, v);
      chk("client_rx", v, `SDO_RX_BASE + nd);
      getobj((c == 1) ? `IDX_CLIENT1 : `IDX_CLIENT2, 8'h03, v);
      chk("client_node", v, nd);
    end
    run(`CODE_LINK, 32'h0000_0005, 32'h0000_0003, 0, 0, 1'b1);
    run(`CODE_LOCAL, `MODE_WRITE_CONST, 32'h0000_0001, {16'h0, `IDX_ROTARY}, 0, 1'b1);
    run(`CODE_LOCAL, 32'h0000_0003, 32'h0000_0001, {16'h0, `IDX_SYNC_PERIOD}, 0, 1'b1);
    // An object missing from the dictionary must stop the program as well
    run(`CODE_LOCAL, `MODE_READ, 32'h0000_0001, 32'h0000_1234, 0, 1'b1);
    rd(`OFS_STATUS, v);
    chk("halt_cleared", {31'h0, program_halt}, 32'h0000_0000);
    chk("flags_cleared", {29'h0, v[3:1]}, 32'h0000_0000);
    wr(ureg(8), 32'h1111_2222);
    wr(ureg(9), 32'h3333_4444);
    run(`CODE_LOCAL, `MODE_WRITE_REG, 32'h0000_0008, {16'h0, `IDX_TIME_OF_DAY}, 0, 1'b0);
    run(`CODE_LOCAL, `MODE_READ, 32'h0000_000A, {16'h0, `IDX_TIME_OF_DAY}, 0, 1'b0);
    rd(ureg(10), v);
    chk("tod_low", v, 32'h1111_2222);
    rd(ureg(11), v);
    chk("tod_high", v, 32'h3333_4444);
    run(`CODE_LOCAL, `MODE_READ, `USER_LAST_NUM, {16'h0, `IDX_TIME_OF_DAY}, 0, 1'b1);
    rd(8'hF0, v);
    chk("unmapped", v, 32'h0000_0000);
    summarize();
  end
endmodule

`default_nettype wire
